/* File: verilog/uct_pkg.sv */
// Shared constants for the serial-interface clock and two-wire drive block
package uct_pkg;

  // Wire mode encodings
  localparam logic [1:0] WM_OFF      = 2'h0;
  localparam logic [1:0] WM_THREE    = 2'h1;
  localparam logic [1:0] WM_TWO      = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  // Clock source encodings and field positions
  localparam logic [1:0] CS_SOFT  = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam int         CS_EXT_BIT = 1;
  localparam int         CS_NEG_BIT = 0;

  // Reset values
  localparam logic       RST_PORT_SCL = 1'h1;
  localparam logic       RST_FLAG     = 1'h0;
  localparam logic       RST_PIN_SYNC = 1'h1;
  localparam logic       RST_PULLUP   = 1'h1;
  localparam logic       RST_IN_READY = 1'h1;

  // Default depth of the sampled-bit buffer
  localparam int         BUF_DEPTH = 2;

endpackage

/* File: verilog/uct_drive.sv */
// Clock selection, line drive and start/overflow hold for the serial interface
//
// Behaviour
// R1 - Mode 10: both lines open-collector, driver enabled only by its direction bit.
// R2 - Two-wire: SDA pulled low when shift output or port bit is zero.
// R3 - Two-wire: SCL pulled low when port bit zero or start detector demands.
// R4 - Detected start with clock output enabled holds SCL low until flag cleared.
// R5 - Two-wire modes disable pull-ups; input paths unchanged.
// R6 - Mode 11 also holds SCL low after overflow until overflow flag cleared.
// R7 - External clock: output latch updates on edge opposite the sampling edge.
// R8 - Strobe or timer clock: output latch transparent.
// R9 - Source 00: strobe write shifts once and counts once, else no clock.
// R10 - Source 01: timer compare match clocks shift register and counter.
// R11 - External: shift on rising (bit0=0) or falling edge; counter counts both.
// R12 - External: strobe bit selects toggle-write as counter clock.
// R13 - Strobe output changes same cycle; shifted-in bit sampled cycle before.
// R14 - Strobe and toggle bits always read back as zero.
// R15 - Toggle write inverts clock port value regardless of direction.
// R16 - External with selector set: each toggle write clocks counter once.
// R17 - Overflow flag set on counter wrap, cleared by writing one, releases hold.
// R18 - Mode 00: outputs, clock hold and start detector disabled.
// R19 - Start is SDA falling while SCL high; sets start flag.
`timescale 1ns/10ps

module uct_drive #(
  parameter int DEPTH = uct_pkg::BUF_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       link_clk,
  input  wire logic [1:0] wire_mode_select,
  input  wire logic [1:0] clock_source_select,
  input  wire logic       ctrl_wr,
  input  wire logic       clock_strobe_bit,
  input  wire logic       toggle_clock_bit,
  input  wire logic       port_scl_wr,
  input  wire logic       port_scl_val,
  input  wire logic       port_sda_bit,
  input  wire logic       sda_dir,
  input  wire logic       clock_pin_direction_bit,
  input  wire logic       timer_match,
  input  wire logic       cnt_wrap,
  input  wire logic       shreg_msb,
  input  wire logic       start_clr,
  input  wire logic       ovf_clr,
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  input  wire logic       bit_ready,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            scl_o,
  output logic            scl_oe,
  output logic            pullup_en,
  output logic            shift_clk,
  output logic            cnt_clk,
  output logic            shift_in_bit,
  output logic            data_out,
  output logic            port_scl,
  output logic            start_condition_flag,
  output logic            counter_overflow_flag,
  output logic            strobe_rd,
  output logic            bit_valid,
  output logic            bit_data,
  output logic            bit_in_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Link-side state: one toggle per link clock edge

  // Link-domain toggles, kept as two registers since each
  // is written by its own edge of the serial clock
  logic rise_tgl_q;
  logic fall_tgl_q;

  // Rising edges of the serial clock
  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
      rise_tgl_q <= 1'b0;
    else
      rise_tgl_q <= ~rise_tgl_q;
  end

  // Falling edges of the serial clock
  always_ff @(negedge link_clk or negedge rstn)
  begin
    if (!rstn)
      fall_tgl_q <= 1'b0;
    else
      fall_tgl_q <= ~fall_tgl_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // System-side state

  typedef struct packed {
    logic [1:0]       rise_s;     // Two-flop sync, then edge compare
    logic             rise_d1;
    logic [1:0]       fall_s;
    logic             fall_d1;
    logic [1:0]       sda_s;
    logic [1:0]       scl_s;
    logic             sda_prev;
    logic             scl_prev;
    logic             sda_samp;
    logic             ext_sel;
    logic             port_scl;
    logic             start_f;
    logic             ovf_f;
    logic             latch;
    logic             sda_oe;
    logic             scl_oe;
    logic             pullup_en;
    logic             shift_clk;
    logic             cnt_clk;
    logic             shift_in;
    logic [DEPTH-1:0] buf_mem;
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             in_ready;
    logic             valid;
    logic             dout;
  } uct_sys_t;

  uct_sys_t s_q;
  uct_sys_t s_d;

  // True when the mode drives two-wire lines
  function automatic logic is_twowire(input logic [1:0] wm);
    is_twowire = (wm == uct_pkg::WM_TWO) || (wm == uct_pkg::WM_TWO_HOLD);
  endfunction

  logic ext_rise;
  logic ext_fall;
  logic ext_mode;
  logic shift_ev;
  logic cnt_ev;
  logic strobe_wr;
  logic toggle_wr;
  logic start_ev;
  logic push;
  logic pop;
  logic two_w;
  logic msb_eff;

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    two_w = is_twowire(wire_mode_select);
    ext_mode = clock_source_select[uct_pkg::CS_EXT_BIT];

    // Link edges crossed by toggle synchronisers
    s_d.rise_s = {s_q.rise_s[0], rise_tgl_q};
    s_d.fall_s = {s_q.fall_s[0], fall_tgl_q};
    s_d.rise_d1 = s_q.rise_s[1];
    s_d.fall_d1 = s_q.fall_s[1];
    ext_rise = s_q.rise_s[1] ^ s_q.rise_d1;
    ext_fall = s_q.fall_s[1] ^ s_q.fall_d1;

    // Pin inputs, synchronised
    s_d.sda_s = {s_q.sda_s[0], sda_i};
    s_d.scl_s = {s_q.scl_s[0], scl_i};
    s_d.sda_prev = s_q.sda_s[1];
    s_d.scl_prev = s_q.scl_s[1];

    // Strobe and toggle pulse only in the cycle of the write; the strobe bit is also held in ext_sel
    // Write strobes
    strobe_wr = ctrl_wr && clock_strobe_bit;
    toggle_wr = ctrl_wr && toggle_clock_bit;
    if (ctrl_wr)
      s_d.ext_sel = clock_strobe_bit;                                  // [R12]

    // Shift register clock source
    shift_ev = 1'b0;
    if (ext_mode)
      shift_ev = clock_source_select[uct_pkg::CS_NEG_BIT] ? ext_fall : ext_rise;  // [R11]
    else if (clock_source_select == uct_pkg::CS_TIMER)
      shift_ev = timer_match;                                          // [R10]
    else
      shift_ev = strobe_wr;                                            // [R9]

    // Counter clock source
    cnt_ev = 1'b0;
    if (ext_mode)
    begin
      if (s_q.ext_sel)
        cnt_ev = toggle_wr;                                            // [R12] [R16]
      else
        cnt_ev = ext_rise || ext_fall;                                 // [R11]
    end
    else if (clock_source_select == uct_pkg::CS_TIMER)
      cnt_ev = timer_match;                                            // [R10]
    else
      cnt_ev = strobe_wr;                                              // [R9]
    s_d.shift_clk = shift_ev;
    s_d.cnt_clk = cnt_ev;

    // Input bit for the shift register is last cycle's sample
    s_d.sda_samp = s_q.sda_s[1];
    s_d.shift_in = s_q.sda_samp;                                       // [R13]

    // Output latch: opposite edge when external, else transparent
    if (ext_mode)
    begin
      if (clock_source_select[uct_pkg::CS_NEG_BIT] ? ext_rise : ext_fall)
        s_d.latch = shreg_msb;                                         // [R7]
    end
    else
      s_d.latch = shreg_msb;                                           // [R8] [R13]

    // Clock port bit and its toggle
    if (toggle_wr)
      s_d.port_scl = ~s_q.port_scl;                                    // [R15]
    else if (port_scl_wr)
      s_d.port_scl = port_scl_val;

    // Two high SCL samples needed, so a clock edge is not taken for a start
    // Start detector: SDA falls while SCL high
    start_ev = (wire_mode_select != uct_pkg::WM_OFF) && s_q.scl_prev && s_q.scl_s[1]
               && s_q.sda_prev && !s_q.sda_s[1];                       // [R19] [R18]
    if (start_ev)
      s_d.start_f = 1'b1;                                              // [R19]
    else if (start_clr)
      s_d.start_f = 1'b0;                                              // [R4]

    // Overflow flag; set wins over clear
    if (cnt_wrap)
      s_d.ovf_f = 1'b1;                                                // [R17]
    else if (ovf_clr)
      s_d.ovf_f = 1'b0;                                                // [R17]

    // Drive enables lag their inputs by one clock
    // Open-collector drivers
    msb_eff = ext_mode ? s_q.latch : shreg_msb;
    s_d.sda_oe = two_w && sda_dir && (!msb_eff || !port_sda_bit);      // [R1] [R2] [R18]
    s_d.scl_oe = two_w && clock_pin_direction_bit
                 && (!s_q.port_scl || s_q.start_f                      // [R3] [R4]
                     || ((wire_mode_select == uct_pkg::WM_TWO_HOLD) && s_q.ovf_f));  // [R6]
    s_d.pullup_en = !two_w;                                            // [R5]

    // A full buffer drops the new bit; the consumer must keep up
    // Two-entry buffer of sampled bits
    push = shift_ev && (s_q.count != 2'(DEPTH));
    pop = (s_q.count != 2'h0) && bit_ready;
    if (push)
    begin
      s_d.buf_mem[s_q.wr_ptr] = s_q.sda_samp;
      s_d.wr_ptr = ~s_q.wr_ptr;
    end
    if (pop)
      s_d.rd_ptr = ~s_q.rd_ptr;
    s_d.count = s_q.count + 2'(push) - 2'(pop);
    s_d.in_ready = (s_d.count != 2'(DEPTH));
    // Registered copies of the buffer head, so outputs come from flops
    s_d.valid = (s_d.count != 2'h0);
    s_d.dout = s_d.buf_mem[s_d.rd_ptr];
  end

  // Pin syncs reset to the idle-high level, so no false start follows reset
  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.rise_s <= 2'h0;
      s_q.sda_s <= {2{uct_pkg::RST_PIN_SYNC}};
      s_q.scl_s <= {2{uct_pkg::RST_PIN_SYNC}};
      s_q.sda_prev <= uct_pkg::RST_PIN_SYNC;
      s_q.scl_prev <= uct_pkg::RST_PIN_SYNC;
      s_q.port_scl <= uct_pkg::RST_PORT_SCL;
      s_q.start_f <= uct_pkg::RST_FLAG;
      s_q.ovf_f <= uct_pkg::RST_FLAG;
      s_q.pullup_en <= uct_pkg::RST_PULLUP;
      s_q.in_ready <= uct_pkg::RST_IN_READY;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops, except the constants sda_o, scl_o and strobe_rd

  assign sda_o = 1'b0;                 // Open collector: only pulls low
  assign scl_o = 1'b0;
  assign sda_oe = s_q.sda_oe;
  assign scl_oe = s_q.scl_oe;
  assign pullup_en = s_q.pullup_en;
  assign shift_clk = s_q.shift_clk;
  assign cnt_clk = s_q.cnt_clk;
  assign shift_in_bit = s_q.shift_in;
  assign data_out = s_q.latch;
  assign port_scl = s_q.port_scl;
  assign start_condition_flag = s_q.start_f;
  assign counter_overflow_flag = s_q.ovf_f;
  assign strobe_rd = 1'b0;              // Strobe and toggle read as zero [R14]
  assign bit_valid = s_q.valid;
  assign bit_data = s_q.dout;
  assign bit_in_ready = s_q.in_ready;

endmodule

/* File: tb/uct_drive_monitor.sv */
// Assertion checker for the serial clock and two-wire drive block
`timescale 1ns/10ps

module uct_drive_monitor (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [1:0] wire_mode_select,
  input wire logic [1:0] clock_source_select,
  input wire logic       ctrl_wr,
  input wire logic       clock_strobe_bit,
  input wire logic       timer_match,
  input wire logic       cnt_wrap,
  input wire logic       ovf_clr,
  input wire logic       clock_pin_direction_bit,
  input wire logic       counter_overflow_flag,
  input wire logic       shift_clk,
  input wire logic       cnt_clk,
  input wire logic       scl_oe,
  input wire logic       pullup_en
);
  // Single system clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Clock source selection
  property p_soft; ctrl_wr && clock_strobe_bit && clock_source_select == 2'h0 |=> shift_clk && cnt_clk; endproperty
  a_soft: assert property (p_soft) else $error("no strobe clock");
  property p_timer; timer_match && clock_source_select == 2'h1 |=> shift_clk && cnt_clk; endproperty
  a_timer: assert property (p_timer) else $error("no timer clock");
  // Overflow flag set, kept and cleared
  property p_oset; cnt_wrap |=> counter_overflow_flag; endproperty
  a_oset: assert property (p_oset) else $error("flag not set");
  property p_okeep; counter_overflow_flag && !ovf_clr |=> counter_overflow_flag; endproperty
  a_okeep: assert property (p_okeep) else $error("flag lost");
  property p_oclr; ovf_clr && !cnt_wrap |=> !counter_overflow_flag; endproperty
  a_oclr: assert property (p_oclr) else $error("flag not cleared");
  // Line drive by mode
  property p_hold; (wire_mode_select == 2'h3 && counter_overflow_flag && clock_pin_direction_bit) [*2]
    |-> scl_oe; endproperty
  a_hold: assert property (p_hold) else $error("no overflow hold");
  property p_pull; wire_mode_select[1] [*2] |-> !pullup_en; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on");
  property p_off; wire_mode_select == 2'h0 [*2] |-> !scl_oe; endproperty
  a_off: assert property (p_off) else $error("drive while off");
endmodule

bind uct_drive uct_drive_monitor u_uct_drive_monitor (.*);

/* File: tb/uct_peer.sv */
// Behavioural two-wire bus peer on the clock and data lines
`timescale 1ns/10ps

module uct_peer (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      link_clk,
  output logic      scl_i,
  output logic      sda_i
);
  logic scl_low = 1'h0;
  logic sda_low = 1'h0;
  // Open-drain lines with pull-ups, idle high
  assign scl_i    = ~(scl_oe | scl_low);
  assign sda_i    = ~(sda_oe | sda_low);
  assign link_clk = scl_i;
  // Start: data falls while clock is high
  task automatic start();
    sda_low = 1'h1;
    #100 sda_low = 1'h0;
  endtask
  // Clock pulses at 64 ns, standing high outside frames
  task automatic frame(input int n);
    repeat (n)
    begin
      #32 scl_low = 1'h1;
      #32 scl_low = 1'h0;
    end
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the serial clock and two-wire drive block
`timescale 1ns/10ps

module tb;
  logic       clk = 1'h0;
  logic       rstn, link_clk, ctrl_wr, clock_strobe_bit, toggle_clock_bit, port_scl_wr, port_scl_val, sda_dir;
  logic       port_sda_bit, clock_pin_direction_bit, timer_match, cnt_wrap, shreg_msb, start_clr, ovf_clr;
  logic       sda_i, scl_i, bit_ready, sda_o, sda_oe, scl_o, scl_oe, pullup_en, shift_clk, cnt_clk, data_out;
  logic       shift_in_bit, port_scl, start_condition_flag, counter_overflow_flag, strobe_rd, bit_valid;
  logic       bit_data, bit_in_ready;
  logic [1:0] wire_mode_select, clock_source_select;
  // Rows: source, write, strobe, toggle, timer, then expected shift and count pulses
  logic [7:0] rows [8] = '{8'h33, 8'h20, 8'h47, 8'h70, 8'hB0, 8'hB9, 8'hF9, 8'h04};
  int         fail_count, checks_done, n_sh, n_cn;

  uct_drive u_uct_drive (.*);
  uct_peer  u_uct_peer (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // System clock
  always #12.5 clk = ~clk;
  // Pulse counters
  always @(posedge clk)
  begin
    n_sh += shift_clk;
    n_cn += cnt_clk;
  end
  // Compare one bit and keep score
  task automatic chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %b want %b", $time, got, exp);
    end
  endtask
  // Wait edges, then settle
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, well past the expected few microseconds
  initial
  begin
    #60000;
    fail_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, ctrl_wr, clock_strobe_bit, toggle_clock_bit, port_scl_wr, port_scl_val, sda_dir, timer_match} = '0;
    {clock_pin_direction_bit, cnt_wrap, start_clr, ovf_clr, bit_ready, wire_mode_select} = '0;
    {port_sda_bit, shreg_msb, clock_source_select} = 4'hC;
    wt(20);
    chk(port_scl, 1'h1);
    $display("reset done");
    @(posedge clk) rstn <= 1'h1;
    foreach (rows[i])
    begin
      @(posedge clk) {clock_source_select, ctrl_wr, clock_strobe_bit, toggle_clock_bit, timer_match} <= rows[i][7:2];
      @(posedge clk) {ctrl_wr, timer_match} <= 2'h0;
      #1;
      chk(shift_clk, rows[i][1]);
      chk(cnt_clk, rows[i][0]);
      chk(strobe_rd, 1'h0);
    end
    $display("table done");
    for (int s = 2; s < 4; s++)
    begin
      @(posedge clk) {clock_source_select, ctrl_wr, clock_strobe_bit, shreg_msb} <= {s[1:0], 2'h2, s[0]};
      @(posedge clk) ctrl_wr <= 1'h0;
      wt(4);
      chk(data_out, !s[0]);
      {n_sh, n_cn} = '0;
      u_uct_peer.frame(2);
      wt(8);
      chk(n_sh == 2, 1'h1);
      chk(n_cn == 4, 1'h1);
      chk(data_out, s[0]);
    end
    $display("edges done");
    repeat (3)
    begin
      @(posedge clk) {clock_source_select, ctrl_wr, clock_strobe_bit} <= 4'h3;
      @(posedge clk) ctrl_wr <= 1'h0;
    end
    wt(2);
    chk(bit_in_ready, 1'h0);
    chk(bit_valid, 1'h1);
    @(posedge clk) bit_ready <= 1'h1;
    wt(4);
    chk(bit_valid, 1'h0);
    @(posedge clk)
    begin
      bit_ready <= 1'h0;
      u_uct_peer.sda_low <= 1'h1;
    end
    wt(4);
    @(posedge clk) ctrl_wr <= 1'h1;
    @(posedge clk) ctrl_wr <= 1'h0;
    wt(2);
    chk(bit_valid, 1'h1);
    chk(bit_data, 1'h0);
    chk(shift_in_bit, 1'h0);
    chk(start_condition_flag, 1'h0);
    @(posedge clk) u_uct_peer.sda_low <= 1'h0;
    $display("buffer done");
    @(posedge clk) {ctrl_wr, clock_strobe_bit, toggle_clock_bit} <= 3'h5;
    @(posedge clk) ctrl_wr <= 1'h0;
    wt(1);
    chk(port_scl, 1'h0);
    @(posedge clk) {wire_mode_select, clock_pin_direction_bit} <= 3'h5;
    wt(4);
    chk(scl_oe, 1'h1);
    @(posedge clk) ctrl_wr <= 1'h1;
    @(posedge clk) {ctrl_wr, toggle_clock_bit} <= 2'h0;
    wt(4);
    chk(port_scl, 1'h1);
    chk(scl_oe, 1'h0);
    u_uct_peer.start();
    wt(4);
    chk(start_condition_flag, 1'h1);
    chk(scl_oe, 1'h1);
    chk(pullup_en, 1'h0);
    @(posedge clk) start_clr <= 1'h1;
    @(posedge clk) start_clr <= 1'h0;
    wt(3);
    chk(scl_oe, 1'h0);
    @(posedge clk) cnt_wrap <= 1'h1;
    @(posedge clk) cnt_wrap <= 1'h0;
    wt(3);
    chk(counter_overflow_flag, 1'h1);
    chk(scl_oe, 1'h0);
    @(posedge clk) wire_mode_select <= 2'h3;
    wt(3);
    chk(scl_oe, 1'h1);
    @(posedge clk) ovf_clr <= 1'h1;
    @(posedge clk) ovf_clr <= 1'h0;
    wt(3);
    chk(counter_overflow_flag, 1'h0);
    chk(scl_oe, 1'h0);
    @(posedge clk) port_sda_bit <= 1'h0;
    wt(3);
    chk(sda_oe, 1'h0);
    @(posedge clk) {sda_dir, port_sda_bit} <= 2'h2;
    wt(3);
    chk(sda_oe, 1'h1);
    @(posedge clk) {port_sda_bit, shreg_msb} <= 2'h2;
    wt(3);
    chk(sda_oe, 1'h1);
    chk(data_out, 1'h0);
    @(posedge clk) wire_mode_select <= 2'h0;
    wt(3);
    chk(sda_oe, 1'h0);
    chk(scl_oe, 1'h0);
    chk(pullup_en, 1'h1);
    $display("hold done");
    wrap_up();
  end
endmodule
